/* src/rss_reset_sequencer.sv */
// Reset source collector and power-on sequencer.
// Assumes mode, watchdog and debugger strobes come from logic on clk;
// supply monitor, reset pin, debug pin and watchdog oscillator are pins.
//
// What this block does
// - Watchdog time-out resets the system in normal/halt, only in reset mode.
// - External reset pin low resets the whole system in normal/halt.
// - Debugger control bit 0 write resets all but the debugger in normal/halt.
// - Power-on or brownout resets the whole system in normal/halt.
// - In stop mode, brownout or reset pin each give a full reset.
// - In stop mode, debug pin low gives a full system reset.
// - Reset is held while the supply monitor reports a low supply.
// - After supply is good, count 66 watchdog oscillator cycles.
// - Then count 16 system clock pulses for oscillator settling.
// - Power-on reset releases only after both counters have expired; other resets only after the settle count.
// - Leaving reset, the processor is told to fetch its reset vector.
// - After a power-on reset the power-on status flag reads 1.
`timescale 1ns/1ps
module rss_reset_sequencer
  import rss_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       supplyLowPin,
  input  wire logic       resetPin_n,
  input  wire logic       debugPin,
  input  wire logic       wdtOscPin,
  input  wire logic       stopMode,
  input  wire logic       wdtTimeout,
  input  wire logic       wdtResetMode,
  input  wire logic       debuggerCtlReset,
  input  wire logic       porFlagClear,
  output logic            sysReset_n,
  output logic            debuggerReset_n,
  output logic            fetchResetVector,
  output logic            porFlag,
  output logic [2:0]      resetCause
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic supplyLowS;
  logic resetPinS_n;
  logic debugPinS;
  logic wdtOscS;

  rss_sync #(.RESET_VAL(SYNC_HIGH)) uSupply (
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn (supplyLowPin),
    .syncOut (supplyLowS)
  );
  rss_sync #(.RESET_VAL(SYNC_HIGH)) uResetPin (
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn (resetPin_n),
    .syncOut (resetPinS_n)
  );
  rss_sync #(.RESET_VAL(SYNC_HIGH)) uDebugPin (
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn (debugPin),
    .syncOut (debugPinS)
  );
  rss_sync #(.RESET_VAL(SYNC_LOW)) uWdtOsc (
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn (wdtOscPin),
    .syncOut (wdtOscS)
  );

  // ****************************************************************
  // Watchdog oscillator edge enable
  // ****************************************************************
  // The slow oscillator is sampled, so each rising edge becomes one enable
  logic wdtOscPrev_reg;
  logic wdtTick;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdtOscPrev_reg <= SYNC_LOW;
    end else begin
      wdtOscPrev_reg <= wdtOscS;
    end
  end

  assign wdtTick = wdtOscS & ~wdtOscPrev_reg;

  // ****************************************************************
  // Reset source qualification
  // ****************************************************************
  logic wdtReq;
  logic debuggerReq;
  logic pinHeld;
  logic debugPinHeld;
  logic warmReq;

  assign wdtReq       = !stopMode && wdtTimeout && wdtResetMode;
  assign debuggerReq  = !stopMode && debuggerCtlReset;
  assign pinHeld      = !resetPinS_n;
  assign debugPinHeld = stopMode && !debugPinS;
  assign warmReq      = wdtReq || debuggerReq || pinHeld || debugPinHeld;

  // ****************************************************************
  // Sequencer next state
  // ****************************************************************
  rss_state_t state_reg;
  rss_state_t state_next;
  logic [6:0] porCnt_reg;
  logic [6:0] porCnt_next;
  logic [4:0] settleCnt_reg;
  logic [4:0] settleCnt_next;
  logic       release_next;
  logic       debuggerHit_next;
  logic [2:0] cause_next;

  always_comb begin
    state_next       = state_reg;
    porCnt_next      = porCnt_reg;
    settleCnt_next   = settleCnt_reg;
    release_next     = 1'b0;
    debuggerHit_next = 1'b0;
    cause_next       = resetCause;
    if (supplyLowS) begin
      // Brownout overrides everything, in every mode
      state_next  = RSS_POR_HOLD;
      porCnt_next = POR_CNT_RESET;
      cause_next  = CAUSE_POR;
    end else begin
      unique case (state_reg)
        RSS_POR_HOLD: begin
          state_next  = RSS_POR_COUNT;
          porCnt_next = POR_CNT_RESET;
        end
        RSS_POR_COUNT: begin
          if (wdtTick) begin
            if (porCnt_reg == POR_CNT_LAST) begin
              state_next     = RSS_SETTLE;
              settleCnt_next = SETTLE_CNT_RESET;
            end else begin
              porCnt_next = porCnt_reg + 7'h01;
            end
          end
        end
        RSS_SETTLE: begin
          if (pinHeld || debugPinHeld) begin
            state_next = RSS_SRC_HOLD;
            // A level pin during a debugger reset widens it to a full reset
            if (resetCause == CAUSE_DEBUGGER) begin
              cause_next = pinHeld ? CAUSE_PIN : CAUSE_DEBUG_PIN;
            end
          end else if (settleCnt_reg == SETTLE_LAST) begin
            state_next   = RSS_RUN;
            release_next = 1'b1;
          end else begin
            settleCnt_next = settleCnt_reg + 5'h01;
          end
        end
        RSS_SRC_HOLD: begin
          // Level sources keep reset until the pin goes back high
          if (!(pinHeld || debugPinHeld)) begin
            state_next     = RSS_SETTLE;
            settleCnt_next = SETTLE_CNT_RESET;
          end else if (resetCause == CAUSE_DEBUGGER) begin
            cause_next = pinHeld ? CAUSE_PIN : CAUSE_DEBUG_PIN;
          end
        end
        RSS_RUN: begin
          if (warmReq) begin
            state_next = RSS_SRC_HOLD;
            if (pinHeld) begin
              cause_next = CAUSE_PIN;
            end else if (debugPinHeld) begin
              cause_next = CAUSE_DEBUG_PIN;
            end else if (wdtReq) begin
              cause_next = CAUSE_WATCHDOG;
            end else begin
              cause_next       = CAUSE_DEBUGGER;
              debuggerHit_next = 1'b1;
            end
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Sequencer state and counters
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= RSS_POR_HOLD;
      porCnt_reg    <= POR_CNT_RESET;
      settleCnt_reg <= SETTLE_CNT_RESET;
    end else begin
      state_reg     <= state_next;
      porCnt_reg    <= porCnt_next;
      settleCnt_reg <= settleCnt_next;
    end
  end

  // ****************************************************************
  // Reset outputs
  // ****************************************************************
  // Assertion is on the same edge as the request; release only leaves
  // the settle state, so every consumer sees one common release edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sysReset_n      <= 1'b0;
      debuggerReset_n <= 1'b0;
    end else if (state_next != RSS_RUN) begin
      sysReset_n <= 1'b0;
      // A debugger-initiated reset leaves the debugger running
      if (!(debuggerHit_next || (debuggerReset_n && cause_next == CAUSE_DEBUGGER))) begin
        debuggerReset_n <= 1'b0;
      end
    end else begin
      sysReset_n      <= 1'b1;
      debuggerReset_n <= 1'b1;
    end
  end

  // One-cycle vector fetch strobe on the release edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fetchResetVector <= 1'b0;
    end else begin
      fetchResetVector <= release_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resetCause <= CAUSE_POR;
    end else begin
      resetCause <= cause_next;
    end
  end

  // Power-on flag: setting on a power-on release beats a same-cycle clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      porFlag <= 1'b0;
    end else if (release_next && cause_next == CAUSE_POR) begin
      porFlag <= 1'b1;
    end else if (porFlagClear) begin
      porFlag <= 1'b0;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_supply_low_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    supplyLowS |=> !sysReset_n && state_reg == RSS_POR_HOLD)
    else $error("Reset not held while supply is low");

  a_por_count_len: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_reg == RSS_POR_COUNT && !supplyLowS && wdtTick && porCnt_reg == 7'h41)
    |=> state_reg == RSS_SETTLE && settleCnt_reg == 5'h00)
    else $error("Power-on count did not end after 66 ticks");

  a_por_count_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_reg == RSS_POR_COUNT && !supplyLowS && !wdtTick)
    |=> state_reg == RSS_POR_COUNT && $stable(porCnt_reg))
    else $error("Power-on counter moved without an oscillator edge");

  a_settle_release: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(sysReset_n) |-> $past(state_reg) == RSS_SETTLE && $past(settleCnt_reg) == 5'h0f)
    else $error("Reset released before the settle count expired");

  a_vector_fetch: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(sysReset_n) |-> fetchResetVector ##1 !fetchResetVector)
    else $error("Reset vector fetch strobe missing or too long");

  a_pin_reset: assert property (
    @(posedge clk) disable iff (!rst_n)
    !resetPinS_n |=> !sysReset_n)
    else $error("Reset pin did not hold the system in reset");

  a_pin_full_reset: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!resetPinS_n || (stopMode && !debugPinS)) |=> !debuggerReset_n)
    else $error("Pin reset left the debugger running");

  a_wdt_reset: assert property (
    @(posedge clk) disable iff (!rst_n)
    (sysReset_n && !stopMode && wdtTimeout && wdtResetMode) |=> !sysReset_n && !debuggerReset_n)
    else $error("Watchdog time-out in reset mode did not reset");

  a_wdt_irq_only: assert property (
    @(posedge clk) disable iff (!rst_n)
    (sysReset_n && !supplyLowS && resetPinS_n && !debuggerCtlReset
     && (!stopMode || debugPinS) && !(wdtTimeout && wdtResetMode && !stopMode))
    |=> sysReset_n)
    else $error("Reset asserted with no qualifying source");

  a_debugger_keep: assert property (
    @(posedge clk) disable iff (!rst_n)
    (sysReset_n && !stopMode && debuggerCtlReset && !supplyLowS && resetPinS_n && !wdtTimeout)
    |=> !sysReset_n && debuggerReset_n)
    else $error("Debugger reset did not spare the debugger");

  a_debug_pin_stop: assert property (
    @(posedge clk) disable iff (!rst_n)
    (stopMode && !debugPinS) |=> !sysReset_n)
    else $error("Debug pin low in stop mode did not reset");

  a_por_flag_set: assert property (
    @(posedge clk) disable iff (!rst_n)
    ($rose(sysReset_n) && resetCause == CAUSE_POR) |-> porFlag)
    else $error("Power-on flag not set after power-on reset");

endmodule

/* src/rss_pkg.sv */
// Constants shared by the reset source and power-on sequencer.
// Assumes one 200 MHz system clock; the watchdog oscillator arrives as a pin.
package rss_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS  = 5;
  // Power-on counter length in watchdog oscillator cycles
  localparam logic [6:0]  POR_OSC_CYCLES = 7'h42;
  localparam logic [6:0]  POR_CNT_LAST   = POR_OSC_CYCLES - 7'h01;
  // Oscillator settle counter length in system clock pulses
  localparam logic [4:0]  SETTLE_CYCLES  = 5'h10;
  localparam logic [4:0]  SETTLE_LAST    = SETTLE_CYCLES - 5'h01;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [6:0]  POR_CNT_RESET    = 7'h00;
  localparam logic [4:0]  SETTLE_CNT_RESET = 5'h00;
  localparam logic        SYNC_LOW         = 1'b0;
  localparam logic        SYNC_HIGH        = 1'b1;

  // ****************************************************************
  // Reset cause codes
  // ****************************************************************
  localparam logic [2:0]  CAUSE_POR       = 3'h0;
  localparam logic [2:0]  CAUSE_WATCHDOG  = 3'h1;
  localparam logic [2:0]  CAUSE_PIN       = 3'h2;
  localparam logic [2:0]  CAUSE_DEBUGGER  = 3'h3;
  localparam logic [2:0]  CAUSE_DEBUG_PIN = 3'h4;

  typedef enum logic [2:0] {
    RSS_POR_HOLD,
    RSS_POR_COUNT,
    RSS_SETTLE,
    RSS_SRC_HOLD,
    RSS_RUN
  } rss_state_t;

endpackage

/* src/rss_sync.sv */
// Two-flop synchroniser for one level arriving from outside the clock domain.
// Assumes the input is a slow level; only the second flop is visible.
`timescale 1ns/1ps
module rss_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic meta_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RESET_VAL;
      syncOut  <= RESET_VAL;
    end else begin
      meta_reg <= asyncIn;
      syncOut  <= meta_reg;
    end
  end

endmodule

/* verif/rss_far_side.sv */
// Far-side model: supply monitor, reset pin, debug pin, watchdog oscillator.
// Assumes the bench changes its hold commands at clk rising edges.
`timescale 1ns/1ps
module rss_far_side #(
  parameter int OSC_HALF = 16
) (
  input  wire logic clk,
  input  wire logic supplyBad,
  input  wire logic pinHold,
  input  wire logic dbgHold,
  output logic      supplyLowPin,
  output logic      resetPin_n,
  output logic      debugPin,
  output logic      wdtOscPin
);
  int oscCnt = 0;

  // ****************************************************************
  // Watchdog oscillator
  // ****************************************************************
  // Runs free through every reset, so its phase is never tied to one
  initial wdtOscPin = 1'b0;
  always @(posedge clk) begin
    if (oscCnt == OSC_HALF - 1) begin
      oscCnt <= 0;
      wdtOscPin <= ~wdtOscPin;
    end else begin
      oscCnt <= oscCnt + 1;
    end
  end

  // ****************************************************************
  // Pins
  // ****************************************************************
  // Reset and debug pins have pull-ups: released reads high
  assign supplyLowPin = supplyBad;
  assign resetPin_n   = ~pinHold;
  assign debugPin     = ~dbgHold;
endmodule

/* verif/rss_reset_sequencer_bench.sv */
// Self-checking bench for the reset source collector and power-on sequencer.
// Assumes rss_far_side drives the pins and the oscillator.
`timescale 1ns/1ps
module rss_reset_sequencer_bench;
  import rss_pkg::*;
  localparam int OSC_HALF = 16;
  localparam int OSC_PER  = 2 * OSC_HALF;
  localparam int LIMIT    = 20000;
  logic       clk = 1'b0;
  logic       rst_n, supplyBad, pinHold, dbgHold;
  logic       supplyLowPin, resetPin_n, debugPin, wdtOscPin;
  logic       stopMode, wdtTimeout, wdtResetMode, debuggerCtlReset, porFlagClear;
  logic       sysReset_n, debuggerReset_n, fetchResetVector, porFlag;
  logic [2:0] resetCause;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  int         cycles = 0;

  always #2.5 clk = ~clk;

  rss_far_side #(.OSC_HALF(OSC_HALF)) farSide (
    .clk(clk), .supplyBad(supplyBad), .pinHold(pinHold), .dbgHold(dbgHold),
    .supplyLowPin(supplyLowPin), .resetPin_n(resetPin_n), .debugPin(debugPin),
    .wdtOscPin(wdtOscPin));

  rss_reset_sequencer dut (
    .clk(clk), .rst_n(rst_n), .supplyLowPin(supplyLowPin), .resetPin_n(resetPin_n),
    .debugPin(debugPin), .wdtOscPin(wdtOscPin), .stopMode(stopMode),
    .wdtTimeout(wdtTimeout), .wdtResetMode(wdtResetMode),
    .debuggerCtlReset(debuggerCtlReset), .porFlagClear(porFlagClear),
    .sysReset_n(sysReset_n), .debuggerReset_n(debuggerReset_n),
    .fetchResetVector(fetchResetVector), .porFlag(porFlag), .resetCause(resetCause));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Counts reset cycles up to release, then checks the vector fetch pulse
  task automatic wait_release(input int lo, input int hi, input logic [2:0] cause);
    int n;
    n = 0;
    while (sysReset_n !== 1'b1 && n < hi + 50) begin
      cyc(1);
      n++;
    end
    check(n >= lo && n <= hi, "reset length");
    check(fetchResetVector === 1'b1 && debuggerReset_n === 1'b1, "no fetch pulse");
    check(resetCause === cause, "wrong cause");
    cyc(1);
    check(fetchResetVector === 1'b0 && sysReset_n === 1'b1, "fetch pulse too long");
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Supply low, then good at a known oscillator phase, so 65 or 67 counts miss the window
  task automatic power_on();
    @(posedge clk);
    supplyBad <= 1'b1;
    cyc(6);
    check(sysReset_n === 1'b0 && debuggerReset_n === 1'b0, "no reset on low supply");
    @(posedge wdtOscPin);
    cyc(8);
    @(posedge clk);
    supplyBad <= 1'b0;
    #1;
    wait_release(66 * OSC_PER, 66 * OSC_PER + 24, CAUSE_POR);
    check(porFlag === 1'b1, "flag not set");
  endtask

  task automatic brownout_mid_count();
    @(posedge clk);
    supplyBad <= 1'b1;
    cyc(4);
    @(posedge clk);
    supplyBad <= 1'b0;
    cyc(30 * OSC_PER);
    check(sysReset_n === 1'b0, "released before count");
    power_on();
  endtask

  task automatic strobe(input logic wdt, input logic mode, input logic stop);
    logic hit;
    hit = !stop && (mode || !wdt);
    @(posedge clk);
    stopMode <= stop;
    wdtResetMode <= mode;
    wdtTimeout <= wdt;
    debuggerCtlReset <= !wdt;
    @(posedge clk);
    wdtTimeout <= 1'b0;
    debuggerCtlReset <= 1'b0;
    stopMode <= 1'b0;
    #1;
    check(sysReset_n === !hit, "strobe response");
    if (hit) begin
      check(debuggerReset_n === !wdt, "debugger domain");
      wait_release(17, 17, wdt ? CAUSE_WATCHDOG : CAUSE_DEBUGGER);
    end
  endtask

  // Reset pin arrives while a debugger reset runs: the debugger must be reset too
  task automatic debugger_then_pin();
    @(posedge clk);
    debuggerCtlReset <= 1'b1;
    pinHold <= 1'b1;
    @(posedge clk);
    debuggerCtlReset <= 1'b0;
    cyc(3);
    check(sysReset_n === 1'b0 && debuggerReset_n === 1'b0, "pin spared debugger");
    @(posedge clk);
    pinHold <= 1'b0;
    #1;
    wait_release(17, 24, CAUSE_PIN);
  endtask

  task automatic pin_hold(input logic dbg, input logic stop, input logic [2:0] cause);
    logic hit;
    hit = dbg ? stop : 1'b1;
    @(posedge clk);
    stopMode <= stop;
    pinHold <= !dbg;
    dbgHold <= dbg;
    cyc(20);
    check(sysReset_n === !hit && debuggerReset_n === !hit, "pin response");
    @(posedge clk);
    pinHold <= 1'b0;
    dbgHold <= 1'b0;
    #1;
    check(sysReset_n === !hit, "release while pin low");
    if (hit) begin
      wait_release(17, 24, cause);
    end
    @(posedge clk);
    stopMode <= 1'b0;
  endtask

  // ****************************************************************
  // Main sequence and timeout
  // ****************************************************************
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial begin
    rst_n = 1'b0;
    supplyBad = 1'b1;
    pinHold = 1'b0;
    dbgHold = 1'b0;
    stopMode = 1'b0;
    wdtTimeout = 1'b0;
    wdtResetMode = 1'b0;
    debuggerCtlReset = 1'b0;
    porFlagClear = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    cyc(2);
    check(sysReset_n === 1'b0 && porFlag === 1'b0, "reset values");
    power_on();
    strobe(1'b1, 1'b0, 1'b0);
    strobe(1'b1, 1'b1, 1'b0);
    strobe(1'b1, 1'b1, 1'b1);
    strobe(1'b0, 1'b0, 1'b0);
    strobe(1'b0, 1'b0, 1'b1);
    debugger_then_pin();
    check(porFlag === 1'b1, "flag lost in warm reset");
    @(posedge clk);
    porFlagClear <= 1'b1;
    @(posedge clk);
    porFlagClear <= 1'b0;
    cyc(1);
    check(porFlag === 1'b0, "flag not cleared");
    pin_hold(1'b0, 1'b0, CAUSE_PIN);
    pin_hold(1'b0, 1'b1, CAUSE_PIN);
    pin_hold(1'b1, 1'b1, CAUSE_DEBUG_PIN);
    pin_hold(1'b1, 1'b0, CAUSE_DEBUG_PIN);
    check(porFlag === 1'b0, "flag set by warm reset");
    brownout_mid_count();
    @(posedge clk);
    stopMode <= 1'b1;
    power_on();
    report_and_stop();
  end
endmodule
